// file: hw/scpr_cfg.svh
// Constants of the serial configuration port host: register offsets,
// field positions, frame geometry and timing.
// Assumes inclusion by bare name from files that need these values.
`ifndef SCPR_CFG_SVH
`define SCPR_CFG_SVH

// Own APB register offsets
`define SCPR_OFF_CTRL 8'h00
`define SCPR_OFF_FRAME 8'h04
`define SCPR_OFF_STATUS 8'h08
`define SCPR_OFF_RXDATA 8'h0c

// Control register bits
`define SCPR_CTRL_GO 0
`define SCPR_CTRL_SYNC_AUTO 1
`define SCPR_CTRL_READBACK 2
`define SCPR_CTRL_RB_HOLD 3

// Status register bits
`define SCPR_ST_BUSY 0
`define SCPR_ST_DONE 1
`define SCPR_ST_REFUSED 2
`define SCPR_ST_ORDER 3
`define SCPR_ST_CAL_STALE 4

// Frame fields
`define SCPR_ADDR_MSB 4
`define SCPR_ADDR_LSB 0
`define SCPR_DIV_MSB 15
`define SCPR_DIV_LSB 5
`define SCPR_DDLY_MSB 27
`define SCPR_DDLY_LSB 18
`define SCPR_RESET_BIT 17
`define SCPR_DIV_LIMIT 11'd25
`define SCPR_DDLY_LIMIT 10'd12

// Register numbers of interest
`define SCPR_REG_R0 5'd0
`define SCPR_REG_LAST_OUT 5'd5
`define SCPR_REG_PLL2_R 5'd28
`define SCPR_REG_OSC_FREQ 5'd29
`define SCPR_REG_CAL 5'd30

// Bit counts, stored as last index and as count
`define SCPR_FRAME_LAST 5'd31
`define SCPR_RB_LAST 5'd26
`define SCPR_EXTRA_LAST 5'd2
`define SCPR_FRAME_BITS 6'd32
`define SCPR_RB_BITS 6'd27
`define SCPR_EXTRA_BITS 6'd3

// Serial clock timing
`define SCPR_CLK_NS 100
`define SCPR_SCLK_HALF_NS 400

`endif

// file: hw/scpr_pkg.sv
// Types of the serial configuration port host.
// Assumes nothing beyond a SystemVerilog compiler.
package scpr_pkg;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_BIT_LO = 4'h1,
    S_BIT_HI = 4'h2,
    S_LE_HI = 4'h3,
    S_XH_HI = 4'h4,
    S_XH_LO = 4'h5,
    S_LE_LO = 4'h6,
    S_XL_HI = 4'h7,
    S_XL_LO = 4'h8,
    S_RB_HI = 4'h9,
    S_RB_LO = 4'ha,
    S_LE_END = 4'hb
  } scpr_state_e;

  // Serial lines driven toward the device
  typedef struct packed {
    logic sclk;
    logic le;
    logic sdo;
  } scpr_pins_s;

  // Per-frame options captured at start
  typedef struct packed {
    logic extra_hi;
    logic extra_lo;
    logic readback;
    logic rb_hold;
  } scpr_opts_s;

endpackage

// file: hw/scpr_tick.sv
// Half-period timer for the serial clock.
// Assumes run_i is low while the sequencer is idle.
`timescale 1ns/1ps
`default_nettype none
module scpr_tick #(
  parameter int HALF_CYC = 4
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  output logic tick_o
);

  logic [7:0] cnt_r;

  // Count while running, restart when stopped
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 8'h00;
    end else if (!run_i || tick_o) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick_o = run_i && (cnt_r == 8'(HALF_CYC - 1));

endmodule
`default_nettype wire

// file: hw/scpr_host.sv
// Host sequencer for a three-wire serial configuration port with readback.
// Assumes an APB master on ref_clk_i and a device whose readback pin and
// oscillator-valid strap arrive asynchronously.
`include "scpr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scpr_host #(
  parameter int HALF_CYC = (`SCPR_SCLK_HALF_NS + `SCPR_CLK_NS - 1) / `SCPR_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic serial_clock_line_o,
  output logic latch_enable_line_o,
  output logic serial_data_o,
  input wire logic readback_pin_i,
  input wire logic osc_valid_i
);

  scpr_pkg::scpr_state_e state_r;
  scpr_pkg::scpr_pins_s pins_r;
  scpr_pkg::scpr_opts_s opts_r;
  scpr_pkg::scpr_opts_s opts_nxt;
  logic [4:0] cnt_r;
  logic [31:0] sh_r;
  logic [26:0] rx_r;
  logic done_r;
  logic cap_r;
  logic [3:0] ctrl_r;
  logic [31:0] frame_r;
  logic st_done_r, st_refused_r, st_order_r, st_cal_stale_r;
  logic r0_seen_r;
  logic [4:0] last_addr_r;
  logic [31:0] prdata_r;
  logic rb_s1_r, rb_s2_r, osc_s1_r, osc_s2_r;
  logic tick;
  logic acc, wr, wr_ctrl, wr_status, go_req, refuse, go_ok, mapped;
  logic [4:0] go_addr;

  function automatic logic [4:0] frame_addr(input logic [31:0] w);
    frame_addr = w[`SCPR_ADDR_MSB:`SCPR_ADDR_LSB];
  endfunction

  // Pin synchronisers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
    end else begin
      rb_s1_r <= readback_pin_i;
      rb_s2_r <= rb_s1_r;
      osc_s1_r <= osc_valid_i;
      osc_s2_r <= osc_s1_r;
    end
  end

  scpr_tick #(.HALF_CYC(HALF_CYC)) u_tick (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .run_i(state_r != scpr_pkg::S_IDLE),
    .tick_o(tick)
  );

  // APB decode, zero wait states
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign mapped = (paddr_i == `SCPR_OFF_CTRL) || (paddr_i == `SCPR_OFF_FRAME) ||
                  (paddr_i == `SCPR_OFF_STATUS) || (paddr_i == `SCPR_OFF_RXDATA);
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prdata_o = prdata_r;
  assign wr_ctrl = wr && (paddr_i == `SCPR_OFF_CTRL);
  assign wr_status = wr && (paddr_i == `SCPR_OFF_STATUS);
  assign go_req = wr_ctrl && pwdata_i[`SCPR_CTRL_GO];
  assign go_addr = frame_addr(frame_r);
  // Reset write to R0 after any earlier accepted R0 write, and calibration without oscillator, refused
  assign refuse = (go_addr == `SCPR_REG_R0 && frame_r[`SCPR_RESET_BIT] && r0_seen_r) ||
                  (go_addr == `SCPR_REG_CAL && !osc_s2_r);
  assign go_ok = go_req && (state_r == scpr_pkg::S_IDLE) && !refuse;

  // Frame options chosen from the frame contents and control bits
  always_comb begin
    logic big;
    big = 1'b0;
    big = (go_addr <= `SCPR_REG_LAST_OUT) &&
          ((frame_r[`SCPR_DIV_MSB:`SCPR_DIV_LSB] > `SCPR_DIV_LIMIT) ||
           (frame_r[`SCPR_DDLY_MSB:`SCPR_DDLY_LSB] > `SCPR_DDLY_LIMIT));
    opts_nxt.extra_hi = big && pwdata_i[`SCPR_CTRL_SYNC_AUTO];
    opts_nxt.extra_lo = big && !pwdata_i[`SCPR_CTRL_SYNC_AUTO] && !pwdata_i[`SCPR_CTRL_READBACK];
    opts_nxt.readback = pwdata_i[`SCPR_CTRL_READBACK];
    opts_nxt.rb_hold = pwdata_i[`SCPR_CTRL_RB_HOLD];
  end

  // Software registers and sticky status, set wins over clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= 4'h0;
      frame_r <= 32'h0000_0000;
      st_done_r <= 1'b0;
      st_refused_r <= 1'b0;
      st_order_r <= 1'b0;
      st_cal_stale_r <= 1'b0;
      r0_seen_r <= 1'b0;
      last_addr_r <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {pwdata_i[3:1], 1'b0};
      end
      if (wr && paddr_i == `SCPR_OFF_FRAME) begin
        frame_r <= pwdata_i;
      end
      if (done_r) begin
        st_done_r <= 1'b1;
      end else if (wr_status && pwdata_i[`SCPR_ST_DONE]) begin
        st_done_r <= 1'b0;
      end
      if (go_req && !go_ok) begin
        st_refused_r <= 1'b1;
      end else if (wr_status && pwdata_i[`SCPR_ST_REFUSED]) begin
        st_refused_r <= 1'b0;
      end
      if (go_ok && go_addr < last_addr_r) begin
        st_order_r <= 1'b1;
      end else if (wr_status && pwdata_i[`SCPR_ST_ORDER]) begin
        st_order_r <= 1'b0;
      end
      if (go_ok && (go_addr == `SCPR_REG_PLL2_R || go_addr == `SCPR_REG_OSC_FREQ)) begin
        st_cal_stale_r <= 1'b1;
      end else if (go_ok && go_addr == `SCPR_REG_CAL) begin
        st_cal_stale_r <= 1'b0;
      end
      if (go_ok) begin
        last_addr_r <= go_addr;
        if (go_addr == `SCPR_REG_R0) begin
          r0_seen_r <= 1'b1;
        end
      end
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      unique case (paddr_i)
        `SCPR_OFF_CTRL: prdata_r <= {28'h0000000, ctrl_r};
        `SCPR_OFF_FRAME: prdata_r <= frame_r;
        `SCPR_OFF_STATUS: prdata_r <= {27'h0000000, st_cal_stale_r, st_order_r, st_refused_r,
                                      st_done_r, state_r != scpr_pkg::S_IDLE};
        `SCPR_OFF_RXDATA: prdata_r <= {5'h00, rx_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Serial sequencer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= scpr_pkg::S_IDLE;
      pins_r <= '0;
      opts_r <= '0;
      cnt_r <= 5'h00;
      sh_r <= 32'h0000_0000;
      rx_r <= 27'h0000000;
      done_r <= 1'b0;
      cap_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      cap_r <= 1'b0;
      unique case (state_r)
        scpr_pkg::S_IDLE: begin
          if (go_ok) begin
            sh_r <= frame_r;
            opts_r <= opts_nxt;
            pins_r.sdo <= frame_r[31];
            pins_r.le <= 1'b0;
            cnt_r <= `SCPR_FRAME_LAST;
            state_r <= scpr_pkg::S_BIT_LO;
          end
        end
        scpr_pkg::S_BIT_LO: begin
          if (tick) begin
            pins_r.sclk <= 1'b1;
            state_r <= scpr_pkg::S_BIT_HI;
          end
        end
        scpr_pkg::S_BIT_HI: begin
          if (tick) begin
            pins_r.sclk <= 1'b0;
            if (cnt_r == 5'h00) begin
              pins_r.le <= 1'b1;
              state_r <= scpr_pkg::S_LE_HI;
            end else begin
              cnt_r <= cnt_r - 5'h01;
              sh_r <= {sh_r[30:0], 1'b0};
              pins_r.sdo <= sh_r[30];
              state_r <= scpr_pkg::S_BIT_LO;
            end
          end
        end
        scpr_pkg::S_LE_HI: begin
          if (tick) begin
            if (opts_r.extra_hi) begin
              pins_r.sclk <= 1'b1;
              cnt_r <= `SCPR_EXTRA_LAST;
              state_r <= scpr_pkg::S_XH_HI;
            end else if (opts_r.readback && opts_r.rb_hold) begin
              pins_r.sclk <= 1'b1;
              cnt_r <= `SCPR_RB_LAST;
              state_r <= scpr_pkg::S_RB_HI;
            end else begin
              pins_r.le <= 1'b0;
              state_r <= scpr_pkg::S_LE_LO;
            end
          end
        end
        scpr_pkg::S_XH_HI: begin
          if (tick) begin
            pins_r.sclk <= 1'b0;
            state_r <= scpr_pkg::S_XH_LO;
          end
        end
        scpr_pkg::S_XH_LO: begin
          if (tick) begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
              pins_r.sclk <= 1'b1;
              state_r <= scpr_pkg::S_XH_HI;
            end else if (opts_r.readback && opts_r.rb_hold) begin
              pins_r.sclk <= 1'b1;
              cnt_r <= `SCPR_RB_LAST;
              state_r <= scpr_pkg::S_RB_HI;
            end else begin
              pins_r.le <= 1'b0;
              state_r <= scpr_pkg::S_LE_LO;
            end
          end
        end
        scpr_pkg::S_LE_LO: begin
          if (tick) begin
            if (opts_r.extra_lo) begin
              pins_r.sclk <= 1'b1;
              cnt_r <= `SCPR_EXTRA_LAST;
              state_r <= scpr_pkg::S_XL_HI;
            end else if (opts_r.readback) begin
              pins_r.sclk <= 1'b1;
              cnt_r <= `SCPR_RB_LAST;
              state_r <= scpr_pkg::S_RB_HI;
            end else begin
              done_r <= 1'b1;
              state_r <= scpr_pkg::S_IDLE;
            end
          end
        end
        scpr_pkg::S_XL_HI: begin
          if (tick) begin
            pins_r.sclk <= 1'b0;
            state_r <= scpr_pkg::S_XL_LO;
          end
        end
        scpr_pkg::S_XL_LO: begin
          if (tick) begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
              pins_r.sclk <= 1'b1;
              state_r <= scpr_pkg::S_XL_HI;
            end else begin
              done_r <= 1'b1;
              state_r <= scpr_pkg::S_IDLE;
            end
          end
        end
        scpr_pkg::S_RB_HI: begin
          if (tick) begin
            pins_r.sclk <= 1'b0;
            rx_r <= {rx_r[25:0], rb_s2_r};
            cap_r <= 1'b1;
            state_r <= scpr_pkg::S_RB_LO;
          end
        end
        scpr_pkg::S_RB_LO: begin
          if (tick) begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
              pins_r.sclk <= 1'b1;
              state_r <= scpr_pkg::S_RB_HI;
            end else if (pins_r.le) begin
              pins_r.le <= 1'b0;
              state_r <= scpr_pkg::S_LE_END;
            end else begin
              done_r <= 1'b1;
              state_r <= scpr_pkg::S_IDLE;
            end
          end
        end
        scpr_pkg::S_LE_END: begin
          if (tick) begin
            done_r <= 1'b1;
            state_r <= scpr_pkg::S_IDLE;
          end
        end
        default: begin
          pins_r <= '0;
          state_r <= scpr_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign serial_clock_line_o = pins_r.sclk;
  assign latch_enable_line_o = pins_r.le;
  assign serial_data_o = pins_r.sdo;

  // Checker helpers: serial clock rises per phase
  logic [5:0] lo_rises_r, hi_rises_r, rb_rises_r;
  logic sclk_q_r;

  // Previous serial clock level, for rise detection
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= pins_r.sclk;
    end
  end

  // Rise counters, cleared at each accepted frame
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_rises_r <= 6'h00;
      hi_rises_r <= 6'h00;
      rb_rises_r <= 6'h00;
    end else if (go_ok) begin
      lo_rises_r <= 6'h00;
      hi_rises_r <= 6'h00;
      rb_rises_r <= 6'h00;
    end else if (pins_r.sclk && !sclk_q_r) begin
      if (!pins_r.le && state_r == scpr_pkg::S_BIT_HI) begin
        lo_rises_r <= lo_rises_r + 6'h01;
      end
      if (pins_r.le && state_r == scpr_pkg::S_XH_HI) begin
        hi_rises_r <= hi_rises_r + 6'h01;
      end
      if (state_r == scpr_pkg::S_RB_HI) begin
        rb_rises_r <= rb_rises_r + 6'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_latch_pulse;
    latch_enable_line_o ##[1:400] !latch_enable_line_o;
  endsequence

  sequence s_last_bit;
    state_r == scpr_pkg::S_BIT_HI && tick && cnt_r == 5'h00;
  endsequence

  chk_frame_bits: assert property ($rose(latch_enable_line_o) |-> lo_rises_r == `SCPR_FRAME_BITS)
    else $error("latch rose before 32 data bits");
  chk_msb_first: assert property (go_ok |=> serial_data_o == $past(frame_r[31]))
    else $error("first serial bit is not bit 31");
  chk_latch_low_shift: assert property ($rose(serial_clock_line_o) && state_r == scpr_pkg::S_BIT_HI
    |-> !latch_enable_line_o)
    else $error("latch high while shifting");
  chk_latch_pulse_follows: assert property (s_last_bit |=> s_latch_pulse)
    else $error("no latch pulse after last bit");
  chk_r30_needs_osc: assert property (go_req && state_r == scpr_pkg::S_IDLE && go_addr == `SCPR_REG_CAL
    && !osc_s2_r |=> state_r == scpr_pkg::S_IDLE && st_refused_r)
    else $error("calibration write sent without oscillator");
  chk_extra_high_three: assert property ($fell(latch_enable_line_o) && opts_r.extra_hi
    |-> hi_rises_r == `SCPR_EXTRA_BITS)
    else $error("wrong extra clocks with latch high");
  chk_r0_reset_once: assert property (go_req && state_r == scpr_pkg::S_IDLE && go_addr == `SCPR_REG_R0
    && frame_r[`SCPR_RESET_BIT] && r0_seen_r |=> state_r == scpr_pkg::S_IDLE && st_refused_r)
    else $error("second R0 reset write sent");
  chk_rb_count: assert property (done_r && opts_r.readback |-> rb_rises_r == `SCPR_RB_BITS)
    else $error("readback did not clock 27 bits");
  chk_sclk_low_le_fall: assert property ($fell(latch_enable_line_o)
    |-> !serial_clock_line_o && $past(!serial_clock_line_o))
    else $error("latch fell with serial clock high");
  chk_sample_at_fall: assert property (cap_r |-> $fell(serial_clock_line_o))
    else $error("readback sampled away from clock fall");
  chk_order_flag: assert property (go_ok && go_addr < last_addr_r |=> st_order_r)
    else $error("descending write not flagged");

endmodule
`default_nettype wire

// file: sim/scpr_dev_model.sv
// Behavioural model of the serially programmed device behind the host.
// Assumes the host drives clock, latch and data; readback pin is push-pull.
`timescale 1ns/1ps
`default_nettype none
module scpr_dev_model #(
  parameter int RB_SEL_LSB = 16
) (
  input wire logic sclk_i,
  input wire logic le_i,
  input wire logic sdi_i,
  output logic rb_pin_o
);
  logic [31:0] sh_r = 32'h0;
  logic [31:0] frame_r = 32'h0;
  logic [26:0] regs_r [32];
  logic [26:0] rb_r = 27'h0;
  logic [4:0] sel_r = 5'h00;
  int rb_n = 0, cnt = 0, xhi = 0, xlo = 0, frames = 0, cals = 0, syncs = 0, errs = 0;

  // Power-on state
  initial begin
    rb_pin_o = 1'b0;
    foreach (regs_r[i]) regs_r[i] = 27'h0;
  end

  // Shift in on rise, present next readback bit on the same rise
  always @(posedge sclk_i) begin
    sh_r = {sh_r[30:0], sdi_i};
    cnt++;
    if (le_i) xhi++; else xlo++;
    if (rb_n > 0) begin
      rb_pin_o <= rb_r[26];
      rb_r = rb_r << 1;
      rb_n--;
    end else begin
      rb_pin_o <= ~rb_pin_o;
    end
  end

  // Latch rise stores the frame and arms readback
  always @(posedge le_i) begin
    if (cnt < 32) errs++;
    frame_r = sh_r;
    frames++;
    if (sh_r[4:0] == 5'd0 && sh_r[17]) foreach (regs_r[i]) regs_r[i] = 27'h0;
    else regs_r[sh_r[4:0]] = sh_r[31:5];
    if (sh_r[4:0] == 5'd31) sel_r = sh_r[RB_SEL_LSB +: 5];
    if (sh_r[4:0] == 5'd30) cals++;
    rb_r = regs_r[sel_r];
    rb_n = 27;
    xhi = 0;
  end

  // Latch fall: sync for output registers, clock must be low
  always @(negedge le_i) begin
    if (sclk_i !== 1'b0) errs++;
    if (frame_r[4:0] <= 5'd5) syncs++;
    xlo = 0;
    cnt = 0;
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the serial configuration port host.
// Assumes the design files and the device model are compiled first.
`include "scpr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic osc_valid = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sclk, le, sdo, rb_pin;
  int fail_count = 0;
  int tests_run = 0;

  // Clock, 100 ns period
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  scpr_host #(.HALF_CYC(4)) dut_u (.ref_clk_i(ref_clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .serial_clock_line_o(sclk), .latch_enable_line_o(le),
    .serial_data_o(sdo), .readback_pin_i(rb_pin), .osc_valid_i(osc_valid));

  scpr_dev_model #(.RB_SEL_LSB(16)) dev_u (.sclk_i(sclk), .le_i(le), .sdi_i(sdo), .rb_pin_o(rb_pin));

  // Verdict and end of run
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check_eq(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        test_done();
      end
      @(posedge ref_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Send one frame, wait for done or refusal, clear flags
  task automatic send(input logic [31:0] f, input logic [2:0] opt, output logic [31:0] st);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    st = 32'h0;
    apb(1'b1, `SCPR_OFF_FRAME, f, q, e);
    apb(1'b1, `SCPR_OFF_CTRL, {28'h0, opt, 1'b1}, q, e);
    while (st[`SCPR_ST_DONE] !== 1'b1 && st[`SCPR_ST_REFUSED] !== 1'b1) begin
      n++;
      if (n > 2000) begin
        fail_count++;
        test_done();
      end
      apb(1'b0, `SCPR_OFF_STATUS, 32'h0, st, e);
    end
    apb(1'b1, `SCPR_OFF_STATUS, 32'h0000_000e, q, e);
  endtask

  // Reset values and unmapped access
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    apb(1'b0, `SCPR_OFF_STATUS, 32'h0, q, e);
    check_eq("status_rst", q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check_eq("unmapped_err", e, 1'b1);
  endtask

  // Plain frame, then a lower address
  task automatic t_plain;
    logic [31:0] st;
    send(32'h7962_d2c6, 3'b000, st);
    check_eq("frame", dev_u.frame_r, 32'h7962_d2c6);
    check_eq("reg6", dev_u.regs_r[6], 32'h7962_d2c6 >> 5);
    check_eq("busy", st[`SCPR_ST_BUSY], 1'b0);
    check_eq("wire_errs", dev_u.errs, 0);
    check_eq("no_extra", dev_u.xlo, 0);
    send(32'h0000_0322, 3'b000, st);
    check_eq("order", st[`SCPR_ST_ORDER], 1'b1);
  endtask

  // Extra clocks for large divider or delay, by sync mode
  task automatic t_extra;
    logic [31:0] st;
    logic [31:0] fr [5] = '{32'h0000_0343, 32'h0000_0343, 32'h0034_0004, 32'h0030_0325, 32'h0000_0346};
    logic [2:0] op [5] = '{3'b001, 3'b000, 3'b001, 3'b000, 3'b001};
    int hi [5] = '{3, 0, 3, 0, 0};
    int lo [5] = '{0, 3, 0, 0, 0};
    int sy [5] = '{1, 1, 1, 1, 0};
    int s;
    for (int i = 0; i < 5; i++) begin
      s = dev_u.syncs;
      send(fr[i], op[i], st);
      check_eq("sync", dev_u.syncs - s, sy[i]);
      check_eq("xhi", dev_u.xhi, hi[i]);
      check_eq("xlo", dev_u.xlo, lo[i]);
      check_eq("frame_x", dev_u.frame_r, fr[i]);
    end
  endtask

  // Reset bit once, second one refused
  task automatic t_reset_bit;
    logic [31:0] st;
    int n;
    send(32'h0002_0000, 3'b000, st);
    check_eq("rst_acc", st[`SCPR_ST_REFUSED], 1'b0);
    check_eq("rst_regs", dev_u.regs_r[3], 27'h0);
    n = dev_u.frames;
    send(32'h0002_0000, 3'b000, st);
    check_eq("rst_ref", st[`SCPR_ST_REFUSED], 1'b1);
    check_eq("rst_quiet", dev_u.frames, n);
    send(32'h0000_0020, 3'b000, st);
    check_eq("r0_acc", st[`SCPR_ST_DONE], 1'b1);
  endtask

  // Calibration needs oscillator, stale flag after divider change
  task automatic t_cal;
    logic [31:0] st;
    int n;
    osc_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    send(32'h0000_001c, 3'b000, st);
    check_eq("stale", st[`SCPR_ST_CAL_STALE], 1'b1);
    n = dev_u.cals;
    send(32'h0000_001e, 3'b000, st);
    check_eq("cal_ref", st[`SCPR_ST_REFUSED], 1'b1);
    check_eq("cal_none", dev_u.cals, n);
    osc_valid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    send(32'h0000_001e, 3'b000, st);
    check_eq("cal_go", dev_u.cals, n + 1);
    check_eq("fresh", st[`SCPR_ST_CAL_STALE], 1'b0);
  endtask

  // Readback in the select write, latch low then latch held
  task automatic t_readback;
    logic [31:0] st;
    logic [31:0] q;
    logic e;
    send(32'h2b3c_4d46, 3'b000, st);
    send(32'h0006_001f, 3'b010, st);
    apb(1'b0, `SCPR_OFF_RXDATA, 32'h0, q, e);
    check_eq("rb_data", q, 32'h2b3c_4d46 >> 5);
    check_eq("rb_clks", dev_u.xlo, 27);
    send(32'h0006_001f, 3'b110, st);
    apb(1'b0, `SCPR_OFF_RXDATA, 32'h0, q, e);
    check_eq("rb_hold", q, 32'h2b3c_4d46 >> 5);
    check_eq("hold_clks", dev_u.xhi, 27);
    check_eq("wire_errs2", dev_u.errs, 0);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    osc_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_plain();
    t_extra();
    t_reset_bit();
    t_cal();
    t_readback();
    test_done();
  end
endmodule
`default_nettype wire
